//--- hw/rch_defines.svh
// Purpose: Register indices, field positions and counts of the hold block
// Assumes: Included by the package and by every design file
// Notes: Byte address of a register is four times its index
`ifndef RCH_DEFINES_SVH
`define RCH_DEFINES_SVH
`define RCH_ADR_W 22
`define RCH_IDX_W 20
`define RCH_IDX_CTRL1 20'hFFF9E
`define RCH_IDX_SEC 20'hFFF92
`define RCH_IDX_IRQ_STAT 20'hFFFA0
`define RCH_IDX_IRQ_MASK 20'hFFFA1
`define RCH_IDX_RUN 20'hFFFA2
`define RCH_CTRL1_RST 8'h00
`define RCH_BIT_HOLD 0
`define RCH_BIT_READY 1
`define RCH_BIT_PFLAG 3
`define RCH_BIT_AFLAG 4
`define RCH_BIT_POE 5
`define RCH_BIT_AIE 6
`define RCH_BIT_AME 7
`define RCH_BIT_RUN 0
`define RCH_IRQ_PERIODIC 0
`define RCH_IRQ_ALARM 1
`define RCH_IRQ_RST 2'h0
`define RCH_SEC_MAX 8'h59
`define RCH_SEC_RST 8'h00
`define RCH_SEC_MASK 8'h7F
`define RCH_WR_XFER_CYC 2'h2
`define RCH_PRESC_LAST 16'hFFFF
`define RCH_PRESC_ZERO 16'h0000
`endif

//--- hw/rch_pkg.sv
// Purpose: Shared types of the counter hold block
// Assumes: rch_defines.svh gives the widths
// Notes: Wishbone field names kept as published
`include "rch_defines.svh"
package rch_pkg;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [`RCH_ADR_W-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } rch_wb_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } rch_wb_rsp_type;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_SETTLE,
        ST_READY,
        ST_DRAIN
    } rch_hold_state_type;
endpackage

//--- hw/rch_prescaler.sv
// Purpose: 16-bit prescaler feeding the seconds counter
// Assumes: Same clock as the owner; clear is a one-cycle pulse
// Notes: Keeps running during a hold so time is not lost
`timescale 1ns/10ps
`include "rch_defines.svh"
module rch_prescaler #(
    parameter logic [15:0] LAST = `RCH_PRESC_LAST
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic clear_i,
    output logic ovf_o,
    output logic [15:0] count_o
);
    logic [15:0] count_r;

    // Overflow marks the last count of each period
    assign ovf_o = run_i && !clear_i && (count_r == LAST);
    assign count_o = count_r;

    // Clear beats counting so a seconds write restarts the second
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            count_r <= `RCH_PRESC_ZERO;
        end else if (run_i) begin
            count_r <= (count_r == LAST) ? `RCH_PRESC_ZERO : count_r + 16'h0001;
        end
    end
endmodule

//--- hw/rch_top.sv
// Purpose: Counter hold handshake, periodic flag and seconds counter
// Assumes: Classic Wishbone slave, 32-bit data, 8-bit registers in low lane
// Notes: Ack comes one cycle after the request; unmapped reads give zero
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/10ps
`include "rch_defines.svh"
module rch_top #(
    parameter logic [15:0] PRESC_LAST = `RCH_PRESC_LAST
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire rch_pkg::rch_wb_req_type wb_req_i,
    output rch_pkg::rch_wb_rsp_type wb_rsp_o,
    input wire logic alarm_match_i,
    input wire logic standby_exit_i,
    output logic periodic_pulse_o,
    output logic rtc_irq_o
);
    import rch_pkg::*;

    logic ack_r;
    logic [31:0] rdat_r;
    logic [`RCH_IDX_W-1:0] idx;
    logic req;
    logic wr_fire;
    logic wr_ctrl;
    logic wr_sec;
    logic wr_stat;
    logic wr_mask;
    logic wr_run;
    logic [7:0] wbyte;
    logic counter_hold_request;
    logic counter_access_ready;
    logic periodic_irq_flag;
    logic alarm_match_flag;
    logic alarm_match_enable;
    logic alarm_irq_enable;
    logic periodic_output_enable;
    logic clock_run_enable;
    logic run_d_r;
    logic settle_r;
    rch_hold_state_type state_r;
    rch_hold_state_type state_nxt;
    logic [7:0] seconds_count;
    logic [7:0] sec_buf_r;
    logic [1:0] xfer_r;
    logic wr_busy;
    logic wr_load;
    logic pend_r;
    logic presc_ovf;
    logic [15:0] presc_count;
    logic count_en;
    logic sec_adv;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic alarm_evt;

    // Two-digit BCD seconds step, wraps after 59
    function automatic logic [7:0] bcd_sec_inc(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (v >= `RCH_SEC_MAX) begin
            r = `RCH_SEC_RST;
        end else if (v[3:0] == 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    // Control byte as software sees it
    function automatic logic [7:0] ctrl_byte(input logic ame, input logic aie, input logic poe,
                                             input logic af, input logic pf, input logic rdy,
                                             input logic hold);
        return {ame, aie, poe, af, pf, 1'b0, rdy, hold};
    endfunction

    // Bus decode; writes land on the edge that sees ack
    assign idx = wb_req_i.adr[`RCH_ADR_W-1:2];
    assign req = wb_req_i.cyc && wb_req_i.stb;
    assign wr_fire = req && wb_req_i.we && ack_r && wb_req_i.sel[0];
    assign wbyte = wb_req_i.dat[7:0];
    assign wr_ctrl = wr_fire && (idx == `RCH_IDX_CTRL1);
    assign wr_sec = wr_fire && (idx == `RCH_IDX_SEC);
    assign wr_stat = wr_fire && (idx == `RCH_IDX_IRQ_STAT);
    assign wr_mask = wr_fire && (idx == `RCH_IDX_IRQ_MASK);
    assign wr_run = wr_fire && (idx == `RCH_IDX_RUN);

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r;
        end
    end

    // Read data captured with ack so it is stable while ack is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_r <= 32'h0000_0000;
        end else if (req && !ack_r) begin
            case (idx)
                `RCH_IDX_CTRL1: rdat_r <= {24'h000000, ctrl_byte(alarm_match_enable, alarm_irq_enable,
                    periodic_output_enable, alarm_match_flag, periodic_irq_flag,
                    counter_access_ready, counter_hold_request)};
                `RCH_IDX_SEC: rdat_r <= {24'h000000, seconds_count & `RCH_SEC_MASK};
                `RCH_IDX_IRQ_STAT: rdat_r <= {30'h0, irq_stat_r};
                `RCH_IDX_IRQ_MASK: rdat_r <= {30'h0, irq_mask_r};
                `RCH_IDX_RUN: rdat_r <= {31'h0, clock_run_enable};
                default: rdat_r <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_rsp_o.ack = ack_r;
    assign wb_rsp_o.dat = rdat_r;

    // Plain control bits of the control byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            counter_hold_request <= 1'b0;
            alarm_match_enable <= 1'b0;
            alarm_irq_enable <= 1'b0;
            periodic_output_enable <= 1'b0;
        end else if (wr_ctrl) begin
            counter_hold_request <= wbyte[`RCH_BIT_HOLD];
            alarm_match_enable <= wbyte[`RCH_BIT_AME];
            alarm_irq_enable <= wbyte[`RCH_BIT_AIE];
            periodic_output_enable <= wbyte[`RCH_BIT_POE];
        end
    end

    // Run enable lives in its own register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clock_run_enable <= 1'b0;
        end else if (wr_run) begin
            clock_run_enable <= wbyte[`RCH_BIT_RUN];
        end
    end

    // One-clock window after run start or standby exit, where hold is slow
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_d_r <= 1'b0;
            settle_r <= 1'b0;
        end else begin
            run_d_r <= clock_run_enable;
            settle_r <= (clock_run_enable && !run_d_r) || standby_exit_i;
        end
    end

    // Hold handshake sequence
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (counter_hold_request) begin
                    state_nxt = settle_r ? ST_SETTLE : ST_READY;
                end
            end
            ST_SETTLE: begin
                state_nxt = counter_hold_request ? ST_READY : ST_RUN;
            end
            ST_READY: begin
                if (!counter_hold_request) begin
                    state_nxt = wr_busy ? ST_DRAIN : ST_RUN;
                end
            end
            ST_DRAIN: begin
                if (counter_hold_request) begin
                    state_nxt = ST_READY;
                end else if (!wr_busy) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign counter_access_ready = (state_r == ST_READY) || (state_r == ST_DRAIN);

    // Seconds write goes through a buffer, loaded two clocks later
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sec_buf_r <= `RCH_SEC_RST;
            xfer_r <= 2'h0;
        end else if (wr_sec) begin
            sec_buf_r <= wbyte & `RCH_SEC_MASK;
            xfer_r <= `RCH_WR_XFER_CYC;
        end else if (wr_busy) begin
            xfer_r <= xfer_r - 2'h1;
        end
    end

    assign wr_busy = (xfer_r != 2'h0);
    assign wr_load = (xfer_r == 2'h1);

    // Prescaler keeps running through a hold
    rch_prescaler #(
        .LAST(PRESC_LAST)
    ) u_presc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(clock_run_enable),
        .clear_i(wr_sec),
        .ovf_o(presc_ovf),
        .count_o(presc_count)
    );

    // Counters advance only with hold released and no write in flight
    assign count_en = clock_run_enable && !counter_hold_request && !wr_busy;
    assign sec_adv = count_en && (presc_ovf || pend_r);

    // Overflow seen while held is kept; a seconds write forgets it
    always_ff @(posedge clk_i) begin
        if (rst_i || wr_sec) begin
            pend_r <= 1'b0;
        end else if (presc_ovf && !count_en) begin
            pend_r <= 1'b1;
        end else if (count_en) begin
            pend_r <= 1'b0;
        end
    end

    // Seconds counter; a buffered write overrides any step
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seconds_count <= `RCH_SEC_RST;
        end else if (wr_load) begin
            seconds_count <= sec_buf_r;
        end else if (sec_adv) begin
            seconds_count <= bcd_sec_inc(seconds_count);
        end
    end

    // Periodic flag: set wins over a clearing write of 0
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            periodic_irq_flag <= 1'b0;
        end else if (sec_adv) begin
            periodic_irq_flag <= 1'b1;
        end else if (wr_ctrl && !wbyte[`RCH_BIT_PFLAG]) begin
            periodic_irq_flag <= 1'b0;
        end
    end

    // Alarm match is only recorded while matching is enabled
    assign alarm_evt = alarm_match_i && alarm_match_enable;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_match_flag <= 1'b0;
        end else if (alarm_evt) begin
            alarm_match_flag <= 1'b1;
        end else if (wr_ctrl && !wbyte[`RCH_BIT_AFLAG]) begin
            alarm_match_flag <= 1'b0;
        end
    end

    // Sticky event status, write one to clear, set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= `RCH_IRQ_RST;
        end else begin
            irq_stat_r[`RCH_IRQ_PERIODIC] <= sec_adv ||
                (irq_stat_r[`RCH_IRQ_PERIODIC] && !(wr_stat && wbyte[`RCH_IRQ_PERIODIC]));
            irq_stat_r[`RCH_IRQ_ALARM] <= (alarm_evt && alarm_irq_enable) ||
                (irq_stat_r[`RCH_IRQ_ALARM] && !(wr_stat && wbyte[`RCH_IRQ_ALARM]));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_r <= `RCH_IRQ_RST;
        end else if (wr_mask) begin
            irq_mask_r <= {wbyte[`RCH_IRQ_ALARM], wbyte[`RCH_IRQ_PERIODIC]};
        end
    end

    // Both sources share the one request line
    assign rtc_irq_o = |(irq_stat_r & irq_mask_r);

    // One-clock pulse per second on the periodic output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            periodic_pulse_o <= 1'b0;
        end else begin
            periodic_pulse_o <= sec_adv && periodic_output_enable;
        end
    end

    a_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        sec_adv |=> periodic_irq_flag)
        else $error("periodic flag not set after step");

    a_flag_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        periodic_irq_flag && wr_ctrl && wbyte[`RCH_BIT_PFLAG] |=> periodic_irq_flag)
        else $error("periodic flag lost on write of one");

    a_ready_fast: assert property (@(posedge clk_i) disable iff (rst_i)
        state_r == ST_RUN && counter_hold_request && !settle_r |=> counter_access_ready)
        else $error("access ready late after hold");

    a_ready_slow: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(counter_hold_request) |-> ##[1:2] counter_access_ready)
        else $error("access ready not up within two clocks");

    a_drain_ready: assert property (@(posedge clk_i) disable iff (rst_i)
        counter_access_ready && wr_busy |=> counter_access_ready)
        else $error("access ready dropped during write");

    a_ready_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !counter_hold_request && !wr_busy && counter_access_ready |=> !counter_access_ready)
        else $error("access ready stuck after release");

    a_sec_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
        counter_hold_request && !wr_load |=> $stable(seconds_count))
        else $error("seconds moved while held");

    a_pend_apply: assert property (@(posedge clk_i) disable iff (rst_i)
        pend_r && count_en |=> seconds_count != $past(seconds_count))
        else $error("kept overflow not applied");

    a_pend_drop: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_sec |=> !pend_r)
        else $error("kept overflow survived seconds write");

    a_presc_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_sec |=> presc_count == `RCH_PRESC_ZERO)
        else $error("prescaler not cleared by seconds write");

    a_irq_shared: assert property (@(posedge clk_i) disable iff (rst_i)
        sec_adv && irq_mask_r[`RCH_IRQ_PERIODIC] |=> rtc_irq_o && periodic_irq_flag)
        else $error("shared irq missing for periodic event");
endmodule

//--- sim/tb_rch_top.sv
// Purpose: Self-checking bench for the counter hold block
// Assumes: Reads answered one cycle after the request; PRESC_LAST shortened to 16 cycles a step
// Notes: Read expectations go in a queue; a monitor pops one on each read ack
`timescale 1ns/10ps
`include "rch_defines.svh"
module tb_rch_top;
    import rch_pkg::*;
    localparam logic [15:0] PL = 16'h000F;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    rch_wb_req_type wb_req = '0;
    rch_wb_rsp_type wb_rsp;
    logic alarm_match_i = 1'b0;
    logic standby_exit_i = 1'b0;
    logic periodic_pulse_o;
    logic rtc_irq_o;
    logic [7:0] exp_q[$];
    int errors = 0;
    int n_compared = 0;
    logic [7:0] v;
    logic [7:0] w;

    rch_top #(.PRESC_LAST(PL)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
        .alarm_match_i(alarm_match_i), .standby_exit_i(standby_exit_i),
        .periodic_pulse_o(periodic_pulse_o), .rtc_irq_o(rtc_irq_o));

    // Clock at 100 MHz
    always #5 clk_i = ~clk_i;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One classic cycle; the request is held until ack is seen at an edge
    task automatic wb(input logic [19:0] idx, input logic we, input logic [7:0] wd, input logic [7:0] exp);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'hF, dat: {24'h0, wd}};
        if (!we) begin
            exp_q.push_back(exp);
        end
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            $display("CHECK FAILED at %0t: no ack", $time);
        end
        wb_req <= '0;
    endtask

    task automatic wr(input logic [19:0] idx, input logic [7:0] d);
        wb(idx, 1'b1, d, 8'h00);
    endtask

    task automatic rd(input logic [19:0] idx, input logic [7:0] exp);
        wb(idx, 1'b0, 8'h00, exp);
    endtask

    // Returns at the edge that ends a seconds step pulse
    task automatic wait_pulse();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (periodic_pulse_o !== 1'b1 && n < 100);
        if (n >= 100) begin
            errors++;
            $display("CHECK FAILED at %0t: no seconds step", $time);
        end
    endtask

    task automatic irq_is(input logic lvl);
        @(posedge clk_i);
        check({7'h0, rtc_irq_o}, {7'h0, lvl});
    endtask

    // Read data monitor; a read ack with nothing queued is a mismatch
    always @(posedge clk_i) begin
        if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0) begin
            if (exp_q.size() == 0) begin
                check(wb_rsp.dat[7:0], 8'hXX);
            end else begin
                check(wb_rsp.dat[7:0], exp_q.pop_front());
            end
        end
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #200000;
        errors++;
        conclude();
    end

    initial begin
        void'($urandom(32'h3b4fae5e));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values and an unmapped place
        rd(`RCH_IDX_CTRL1, `RCH_CTRL1_RST);
        rd(`RCH_IDX_SEC, `RCH_SEC_RST);
        rd(`RCH_IDX_IRQ_STAT, 8'h00);
        rd(`RCH_IDX_IRQ_MASK, 8'h00);
        rd(`RCH_IDX_RUN, 8'h00);
        wr(20'h00123, 8'hFF);
        rd(20'h00123, 8'h00);
        $display("test reset done");
        // Plain hold is ready by the first read, then release
        wr(`RCH_IDX_CTRL1, 8'h19);
        rd(`RCH_IDX_CTRL1, 8'h03);
        wr(`RCH_IDX_CTRL1, 8'h18);
        rd(`RCH_IDX_CTRL1, 8'h00);
        // Standby exit seen on the same edge as the hold write: one clock slower
        fork
            wr(`RCH_IDX_CTRL1, 8'h19);
            begin
                repeat (2) @(posedge clk_i);
                standby_exit_i <= 1'b1;
                @(posedge clk_i) standby_exit_i <= 1'b0;
            end
        join
        rd(`RCH_IDX_CTRL1, 8'h01);
        rd(`RCH_IDX_CTRL1, 8'h03);
        wr(`RCH_IDX_CTRL1, 8'h18);
        rd(`RCH_IDX_CTRL1, 8'h00);
        $display("test hold done");
        // Periodic flag, keep on one, clear on zero, irq and mask
        wr(`RCH_IDX_RUN, 8'h01);
        wr(`RCH_IDX_IRQ_MASK, 8'h01);
        wr(`RCH_IDX_CTRL1, 8'h38);
        wait_pulse();
        irq_is(1'b1);
        rd(`RCH_IDX_CTRL1, 8'h28);
        wr(`RCH_IDX_CTRL1, 8'h38);
        rd(`RCH_IDX_CTRL1, 8'h28);
        wait_pulse();
        wr(`RCH_IDX_CTRL1, 8'h30);
        rd(`RCH_IDX_CTRL1, 8'h20);
        wr(`RCH_IDX_IRQ_STAT, 8'h01);
        irq_is(1'b0);
        wr(`RCH_IDX_IRQ_MASK, 8'h00);
        wait_pulse();
        irq_is(1'b0);
        rd(`RCH_IDX_IRQ_STAT, 8'h01);
        $display("test periodic done");
        // Alarm event on the shared irq, counting stopped
        wr(`RCH_IDX_RUN, 8'h00);
        wr(`RCH_IDX_IRQ_STAT, 8'h03);
        wr(`RCH_IDX_IRQ_MASK, 8'h02);
        wr(`RCH_IDX_CTRL1, 8'hD0);
        @(posedge clk_i) alarm_match_i <= 1'b1;
        @(posedge clk_i) alarm_match_i <= 1'b0;
        irq_is(1'b1);
        rd(`RCH_IDX_CTRL1, 8'hD0);
        rd(`RCH_IDX_IRQ_STAT, 8'h02);
        wr(`RCH_IDX_CTRL1, 8'hC8);
        rd(`RCH_IDX_CTRL1, 8'hC0);
        wr(`RCH_IDX_IRQ_STAT, 8'h02);
        irq_is(1'b0);
        wr(`RCH_IDX_IRQ_MASK, 8'h00);
        wr(`RCH_IDX_CTRL1, 8'h00);
        $display("test alarm done");
        // Overflow kept across a hold, then dropped by a seconds write
        v = {1'b0, 3'($urandom % 6), 4'($urandom % 9)};
        w = {1'b0, 3'($urandom % 6), 4'($urandom % 10)};
        wr(`RCH_IDX_CTRL1, 8'h01);
        rd(`RCH_IDX_CTRL1, 8'h03);
        wr(`RCH_IDX_RUN, 8'h01);
        wr(`RCH_IDX_SEC, v);
        repeat (18) @(posedge clk_i);
        rd(`RCH_IDX_SEC, v);
        wr(`RCH_IDX_CTRL1, 8'h18);
        rd(`RCH_IDX_SEC, v + 8'h01);
        wr(`RCH_IDX_CTRL1, 8'h19);
        rd(`RCH_IDX_CTRL1, 8'h0B);
        repeat (20) @(posedge clk_i);
        wr(`RCH_IDX_SEC, w);
        wr(`RCH_IDX_CTRL1, 8'h18);
        rd(`RCH_IDX_SEC, w);
        rd(`RCH_IDX_CTRL1, 8'h08);
        $display("test overflow done");
        conclude();
    end
endmodule
